// *** rtl/drs_ready_seq.sv ***
// Device ready sequencer with strap capture and register file
`timescale 1ns/100ps
`include "drs_cfg.svh"
// What this block does
// - Read-only ready flag, PMC bit 0
// - Ready rising edge sets interrupt status bit
// - Ready mirrored at hardware config bit 27
// - Ready after reset waits for EEPROM load
// - Core reset reloads EEPROM, ready low
// - Any low-power state drops ready
// - Wake ready needs full power, stable PLL
// - Straps captured only on reset events
// - Straps drive configuration or register defaults
// - EEPROM range strap selects address span
// - Port mode 10 three-port downstream
// - Port mode 11 three-port upstream
// - Link polarity strap sets MII link level
// - TX shift strap selects 0-30 ns
// - PHY A fiber strap selects FX mode
// - PHY B fiber strap selects FX mode
// - PHY A LOS strap selects LOS mode
// - PHY B LOS strap selects LOS mode
// - Wake clears sleep and mode fields
module drs_ready_seq #(
  parameter int PLL_LOCK_CYC = (`DRS_PLL_LOCK_NS * `DRS_CLK_MHZ + 999) / 1000
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        por_event,
  input  wire logic        pin_reset_event,
  input  wire logic        eeprom_done,
  input  wire logic        wake_event,
  input  wire logic        pll_locked,
  input  wire logic        mii_link_pin,
  input  wire logic        eeprom_range_pin,
  input  wire logic [1:0]  port_mode_pin,
  input  wire logic        link_pol_pin,
  input  wire logic [1:0]  tx_shift_pin,
  input  wire logic        phy_a_fiber_strap,
  input  wire logic        phy_b_fiber_strap,
  input  wire logic        phy_a_los_select_strap,
  input  wire logic        phy_b_los_select_strap,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             eeprom_reload_reg,
  output logic             ready_reg,
  output logic             mii_link_up_reg,
  output drs_pkg::drs_cfg_t cfg_out
);
  drs_pkg::drs_state_t state_reg;
  drs_pkg::drs_state_t state_next;
  drs_pkg::drs_strap_t strap_sync1_reg;
  drs_pkg::drs_strap_t strap_sync2_reg;
  drs_pkg::drs_strap_t strap_in;
  drs_pkg::drs_strap_t strap_q;
  logic [1:0]  ev_meta_reg;
  logic [1:0]  ev_sync_reg;
  logic [1:0]  io_meta_reg;
  logic [1:0]  io_sync_reg;
  logic        sleep_request_bit;
  logic [2:0]  power_state_select;
  logic        ready_prev_reg;
  logic        int_ready_reg;
  logic        capture_reg;
  logic [15:0] pll_cnt_reg;
  logic        wr_pulse;
  logic [7:0]  wr_addr;
  logic [31:0] wr_data;
  logic [3:0]  wr_strb;
  logic [7:0]  rd_addr;
  logic        rd_pulse;
  logic [31:0] rd_data;
  logic        rd_ok;
  logic        wr_ok;
  logic        wr_pmc;
  logic        wr_int;
  logic        wr_rst;
  logic        core_reset_req;
  logic        dig_reset_req;
  logic        wake_s;
  logic        pll_s;
  logic        sleep_go;
  logic        ready_rise;
  logic        pll_done;
  logic        allowed_rd;
  logic [31:0] power_mgmt_control_reg;
  logic [31:0] hardware_config_reg;
  logic [31:0] interrupt_status_reg;

  // Address decode is shared by both directions
  function automatic logic is_reg(input logic [7:0] a, input logic [7:0] off);
    return a == off;
  endfunction : is_reg

  // Two-flop synchronisers for pins and asynchronous status
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      strap_sync1_reg <= '0;
      strap_sync2_reg <= '0;
      ev_meta_reg     <= 2'h0;
      ev_sync_reg     <= 2'h0;
      io_meta_reg     <= 2'h0;
      io_sync_reg     <= 2'h0;
    end else begin
      strap_sync1_reg <= strap_in;
      strap_sync2_reg <= strap_sync1_reg;
      ev_meta_reg     <= {wake_event, pll_locked};
      ev_sync_reg     <= ev_meta_reg;
      io_meta_reg     <= {mii_link_pin, 1'b0};
      io_sync_reg     <= io_meta_reg;
    end
  end

  assign strap_in = {eeprom_range_pin, drs_pkg::drs_port_mode_t'(port_mode_pin), link_pol_pin,
                     tx_shift_pin, phy_a_fiber_strap, phy_b_fiber_strap,
                     phy_a_los_select_strap, phy_b_los_select_strap};
  assign wake_s   = ev_sync_reg[1];
  assign pll_s    = ev_sync_reg[0];

  drs_axil_slave u_bus (
    .clk     (clk),
    .rst_n   (rst_n),
    .awaddr  (s_axi_awaddr),
    .awvalid (s_axi_awvalid),
    .awready (s_axi_awready),
    .wdata   (s_axi_wdata),
    .wstrb   (s_axi_wstrb),
    .wvalid  (s_axi_wvalid),
    .wready  (s_axi_wready),
    .bresp   (s_axi_bresp),
    .bvalid  (s_axi_bvalid),
    .bready  (s_axi_bready),
    .araddr  (s_axi_araddr),
    .arvalid (s_axi_arvalid),
    .arready (s_axi_arready),
    .rdata   (s_axi_rdata),
    .rresp   (s_axi_rresp),
    .rvalid  (s_axi_rvalid),
    .rready  (s_axi_rready),
    .wr_pulse(wr_pulse),
    .wr_addr (wr_addr),
    .wr_data (wr_data),
    .wr_strb (wr_strb),
    .wr_ok   (wr_ok),
    .rd_addr (rd_addr),
    .rd_pulse(rd_pulse),
    .rd_data (rd_data),
    .rd_ok   (rd_ok)
  );

  drs_strap_latch u_strap (
    .clk        (clk),
    .rst_n      (rst_n),
    .capture    (capture_reg),
    .strap_in   (strap_sync2_reg),
    .strap_reg  (strap_q),
    .cfg_reg    (cfg_out),
    .mii_link_up()
  );

  // Write strobes; only the top byte lane carries the power fields
  assign wr_pmc         = wr_pulse && is_reg(wr_addr, `DRS_OFF_PMC) && wr_strb[3];
  assign wr_int         = wr_pulse && is_reg(wr_addr, `DRS_OFF_INTSTS) && wr_strb[3];
  assign wr_rst         = wr_pulse && is_reg(wr_addr, `DRS_OFF_RSTCTL) && wr_strb[0];
  assign core_reset_req = wr_rst && wr_data[`DRS_RST_CORE_BIT];
  assign dig_reset_req  = wr_rst && wr_data[`DRS_RST_DIG_BIT];
  // Sleep bit is refused when written together with a new mode
  assign sleep_go       = wr_pmc && wr_data[`DRS_SLEEP_BIT] && state_reg == drs_pkg::DRS_READY
                          && wr_data[31:29] == power_state_select && power_state_select != 3'h0;
  assign pll_done       = pll_cnt_reg == 16'(PLL_LOCK_CYC);
  assign ready_rise     = ready_reg && !ready_prev_reg;
  assign wr_ok          = !wr_pulse || is_reg(wr_addr, `DRS_OFF_PMC)
                          || is_reg(wr_addr, `DRS_OFF_INTSTS) || is_reg(wr_addr, `DRS_OFF_RSTCTL)
                          || is_reg(wr_addr, `DRS_OFF_HWC) || is_reg(wr_addr, `DRS_OFF_STRAP)
                          || is_reg(wr_addr, `DRS_OFF_TEST);

  // Ready sequence state machine
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      drs_pkg::DRS_RESET:   state_next = drs_pkg::DRS_LOAD;
      drs_pkg::DRS_LOAD:    if (eeprom_done) state_next = drs_pkg::DRS_READY;
      drs_pkg::DRS_READY:   if (sleep_go) state_next = drs_pkg::DRS_SLEEP;
      drs_pkg::DRS_SLEEP:   if (wake_s) state_next = drs_pkg::DRS_PLLWAIT;
      drs_pkg::DRS_PLLWAIT: if (pll_s && pll_done) state_next = drs_pkg::DRS_READY;
      default:              state_next = drs_pkg::DRS_RESET;
    endcase
    if (por_event || pin_reset_event || core_reset_req || dig_reset_req) begin
      state_next = drs_pkg::DRS_RESET;
    end
  end

  // State, ready flag and reset-event capture
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_reg         <= drs_pkg::DRS_RESET;
      ready_reg         <= 1'b0;
      ready_prev_reg    <= 1'b0;
      capture_reg       <= 1'b0;
      eeprom_reload_reg <= 1'b0;
    end else begin
      state_reg         <= state_next;
      ready_reg         <= state_next == drs_pkg::DRS_READY;
      ready_prev_reg    <= ready_reg;
      capture_reg       <= por_event || pin_reset_event || core_reset_req;
      eeprom_reload_reg <= state_next == drs_pkg::DRS_RESET;
    end
  end

  // PLL settle counter runs only while waiting after wake
  always_ff @(posedge clk) begin
    if (!rst_n || state_reg != drs_pkg::DRS_PLLWAIT || !pll_s) begin
      pll_cnt_reg <= 16'h0;
    end else if (!pll_done) begin
      pll_cnt_reg <= pll_cnt_reg + 16'h1;
    end
  end

  // Power fields: sleep is self-clearing on wake
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sleep_request_bit  <= 1'b0;
      power_state_select <= 3'h0;
    end else if (wake_s && state_reg == drs_pkg::DRS_SLEEP) begin
      sleep_request_bit  <= 1'b0;
      power_state_select <= 3'h0;
    end else if (sleep_go) begin
      sleep_request_bit  <= 1'b1;
    end else if (wr_pmc && ready_reg && !wr_data[`DRS_SLEEP_BIT]) begin
      power_state_select <= wr_data[31:29];
    end
  end

  // Sticky ready interrupt; a new edge wins over a clear
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      int_ready_reg <= 1'b0;
    end else if (ready_rise) begin
      int_ready_reg <= 1'b1;
    end else if (wr_int && wr_data[`DRS_INT_READY_BIT]) begin
      int_ready_reg <= 1'b0;
    end
  end

  // Link polarity applied after synchronising the pin
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mii_link_up_reg <= 1'b0;
    end else begin
      mii_link_up_reg <= io_sync_reg[1] == strap_q.link_pol;
    end
  end

  // Read views; both ready locations come from one flop
  assign power_mgmt_control_reg = {power_state_select, sleep_request_bit, 27'h0, ready_reg};
  assign hardware_config_reg    = {4'h0, ready_reg, 27'h0};
  assign interrupt_status_reg   = {1'b0, int_ready_reg, 30'h0};
  // Before ready only the early registers answer; other reads get a decode error
  assign allowed_rd = is_reg(rd_addr, `DRS_OFF_PMC) || is_reg(rd_addr, `DRS_OFF_HWC)
                      || is_reg(rd_addr, `DRS_OFF_TEST) || is_reg(rd_addr, `DRS_OFF_RSTCTL);
  assign rd_ok      = allowed_rd || (ready_reg && (is_reg(rd_addr, `DRS_OFF_INTSTS)
                      || is_reg(rd_addr, `DRS_OFF_STRAP)));
  assign rd_data    = !rd_ok ? 32'h0
                    : is_reg(rd_addr, `DRS_OFF_PMC)    ? power_mgmt_control_reg
                    : is_reg(rd_addr, `DRS_OFF_HWC)    ? hardware_config_reg
                    : is_reg(rd_addr, `DRS_OFF_INTSTS) ? interrupt_status_reg
                    : is_reg(rd_addr, `DRS_OFF_TEST)   ? `DRS_TEST_VALUE
                    : is_reg(rd_addr, `DRS_OFF_STRAP)  ? {22'h0, strap_q}
                    : 32'h0;

  // Checks
  sequence s_load_done;
    state_reg == drs_pkg::DRS_LOAD && eeprom_done;
  endsequence
  property p_ready_after_load;
    @(posedge clk) disable iff (!rst_n)
      s_load_done and !(por_event || pin_reset_event || core_reset_req || dig_reset_req)
      |=> ready_reg;
  endproperty
  a_ready_after_load: assert property (p_ready_after_load) else $error("ready late");
  property p_mirror;
    @(posedge clk) disable iff (!rst_n) hardware_config_reg[27] == power_mgmt_control_reg[0];
  endproperty
  a_mirror: assert property (p_mirror) else $error("ready mirror differs");
  property p_int_on_rise;
    @(posedge clk) disable iff (!rst_n) $rose(ready_reg) |=> int_ready_reg;
  endproperty
  a_int_on_rise: assert property (p_int_on_rise) else $error("ready int missed");
  property p_core_reset_low;
    @(posedge clk) disable iff (!rst_n) core_reset_req |=> !ready_reg ##1 !ready_reg;
  endproperty
  a_core_reset_low: assert property (p_core_reset_low) else $error("ready high in reload");
  property p_sleep_low;
    @(posedge clk) disable iff (!rst_n) sleep_go |=> !ready_reg;
  endproperty
  a_sleep_low: assert property (p_sleep_low) else $error("ready high asleep");
  property p_wake_pll;
    @(posedge clk) disable iff (!rst_n)
      $rose(ready_reg) && $past(state_reg) == drs_pkg::DRS_PLLWAIT |-> $past(pll_s);
  endproperty
  a_wake_pll: assert property (p_wake_pll) else $error("ready before pll");
  property p_strap_hold;
    @(posedge clk) disable iff (!rst_n) !capture_reg |=> $stable(strap_q);
  endproperty
  a_strap_hold: assert property (p_strap_hold) else $error("strap changed");
  property p_wake_clear;
    @(posedge clk) disable iff (!rst_n)
      wake_s && state_reg == drs_pkg::DRS_SLEEP |=> !sleep_request_bit && power_state_select == 3'h0;
  endproperty
  a_wake_clear: assert property (p_wake_clear) else $error("power fields kept");
endmodule : drs_ready_seq

// *** pkg/drs_cfg.svh ***
// Register offsets, field positions, response codes, test word and timing constants for the ready/strap block
`ifndef DRS_CFG_SVH
`define DRS_CFG_SVH
`define DRS_OFF_PMC        8'h00
`define DRS_OFF_HWC        8'h04
`define DRS_OFF_INTSTS     8'h08
`define DRS_OFF_RSTCTL     8'h0c
`define DRS_OFF_STRAP      8'h10
`define DRS_OFF_TEST       8'h14
`define DRS_READY_BIT      0
`define DRS_HWC_READY_BIT  27
`define DRS_SLEEP_BIT      28
`define DRS_PMODE_LSB      29
`define DRS_INT_READY_BIT  30
`define DRS_RST_CORE_BIT   6
`define DRS_RST_DIG_BIT    0
`define DRS_TEST_VALUE     32'h87654321
`define DRS_DECERR         2'h3
`define DRS_OKAY           2'h0
`define DRS_PLL_LOCK_NS    1000
`define DRS_CLK_MHZ        40
`endif

// *** pkg/drs_pkg.sv ***
// Types shared by the ready/strap block
package drs_pkg;
  typedef enum logic [2:0] {
    DRS_RESET   = 3'b000,
    DRS_LOAD    = 3'b001,
    DRS_READY   = 3'b010,
    DRS_SLEEP   = 3'b011,
    DRS_PLLWAIT = 3'b100
  } drs_state_t;

  typedef enum logic [1:0] {
    DRS_TWO_PORT  = 2'b00,
    DRS_PORT_RSVD = 2'b01,
    DRS_THREE_DN  = 2'b10,
    DRS_THREE_UP  = 2'b11
  } drs_port_mode_t;

  // Captured hard straps
  typedef struct packed {
    logic           eeprom_range;
    drs_port_mode_t port_mode;
    logic           link_pol;
    logic [1:0]     tx_shift;
    logic           phy_a_fiber;
    logic           phy_b_fiber;
    logic           phy_a_los;
    logic           phy_b_los;
  } drs_strap_t;

  // Configuration derived from the straps
  typedef struct packed {
    logic       eeprom_large;
    logic [1:0] phya_port;
    logic [1:0] phyb_port;
    logic [1:0] mii_port;
    logic       mii_used;
    logic [4:0] tx_shift_ns;
    logic       phy_a_fx;
    logic       phy_b_fx;
    logic       phy_a_los_mode;
    logic       phy_b_los_mode;
  } drs_cfg_t;
endpackage : drs_pkg

// *** rtl/drs_strap_latch.sv ***
// Hard strap capture and decode into configuration values
`timescale 1ns/100ps
`include "drs_cfg.svh"
module drs_strap_latch (
  input  wire logic                clk,
  input  wire logic                rst_n,
  input  wire logic                capture,
  input  wire drs_pkg::drs_strap_t strap_in,
  output drs_pkg::drs_strap_t      strap_reg,
  output drs_pkg::drs_cfg_t        cfg_reg,
  output logic                     mii_link_up
);
  drs_pkg::drs_cfg_t cfg_next;

  // Capture only on a reset event, otherwise hold
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      strap_reg <= '0;
    end else if (capture) begin
      strap_reg <= strap_in;
    end
  end

  // Straps used directly or decoded into configuration values
  assign cfg_next.eeprom_large   = strap_reg.eeprom_range;
  assign cfg_next.phya_port      = (strap_reg.port_mode == drs_pkg::DRS_THREE_UP)
                                   ? 2'h2 : 2'h0;
  assign cfg_next.phyb_port      = 2'h1;
  assign cfg_next.mii_port       = (strap_reg.port_mode == drs_pkg::DRS_THREE_UP)
                                   ? 2'h0 : 2'h2;
  assign cfg_next.mii_used       = strap_reg.port_mode[1];
  assign cfg_next.tx_shift_ns    = 5'({strap_reg.tx_shift, 3'h0} + {strap_reg.tx_shift, 1'h0});
  assign cfg_next.phy_a_fx       = strap_reg.phy_a_fiber;
  assign cfg_next.phy_b_fx       = strap_reg.phy_b_fiber;
  assign cfg_next.phy_a_los_mode = strap_reg.phy_a_los;
  assign cfg_next.phy_b_los_mode = strap_reg.phy_b_los;

  // Registered so outputs come from flops
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cfg_reg <= '0;
    end else begin
      cfg_reg <= cfg_next;
    end
  end

  // Link input is sampled and its polarity applied by the top level; this output stays low
  logic mii_link_s;
  assign mii_link_s = 1'b0;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mii_link_up <= 1'b0;
    end else begin
      mii_link_up <= mii_link_s;
    end
  end
endmodule : drs_strap_latch

// *** rtl/drs_axil_slave.sv ***
// AXI4-Lite slave front end: one write and one read at a time
`timescale 1ns/100ps
module drs_axil_slave (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  output logic             wr_pulse,
  output logic [7:0]       wr_addr,
  output logic [31:0]      wr_data,
  output logic [3:0]       wr_strb,
  input  wire logic        wr_ok,
  output logic [7:0]       rd_addr,
  output logic             rd_pulse,
  input  wire logic [31:0] rd_data,
  input  wire logic        rd_ok
);
  logic aw_held_reg;
  logic w_held_reg;
  logic wr_go;
  logic rd_go;

  assign awready  = !aw_held_reg && !bvalid;
  assign wready   = !w_held_reg && !bvalid;
  assign wr_go    = (aw_held_reg || (awvalid && awready)) && (w_held_reg || (wvalid && wready));
  assign arready  = !rvalid;
  assign rd_go    = arvalid && arready;
  assign rd_addr  = araddr;
  assign rd_pulse = rd_go;

  // Address and data may arrive in either order
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      aw_held_reg <= 1'b0;
      w_held_reg  <= 1'b0;
      wr_addr     <= 8'h00;
      wr_data     <= 32'h0;
      wr_strb     <= 4'h0;
      wr_pulse    <= 1'b0;
    end else begin
      wr_pulse <= wr_go;
      if (awvalid && awready) begin
        wr_addr <= awaddr;
      end
      if (wvalid && wready) begin
        wr_data <= wdata;
        wr_strb <= wstrb;
      end
      aw_held_reg <= wr_go ? 1'b0 : (aw_held_reg || (awvalid && awready));
      w_held_reg  <= wr_go ? 1'b0 : (w_held_reg || (wvalid && wready));
    end
  end

  // Response one cycle after the write is applied
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      bvalid <= 1'b0;
      bresp  <= 2'h0;
    end else if (wr_pulse) begin
      bvalid <= 1'b1;
      bresp  <= wr_ok ? 2'h0 : 2'h3;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // Reads answer the cycle after the address is taken
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rvalid <= 1'b0;
      rdata  <= 32'h0;
      rresp  <= 2'h0;
    end else if (rd_go) begin
      rvalid <= 1'b1;
      rdata  <= rd_data;
      rresp  <= rd_ok ? 2'h0 : 2'h3;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end
endmodule : drs_axil_slave

// *** testbench/drs_env_model.sv ***
// Far-side model: finishes each configuration load some cycles after the request ends
`timescale 1ns/100ps
module drs_env_model #(
  parameter int LOAD_CYC = 12
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic load_req,
  output logic      load_done
);
  int cnt;
  // Restart the count while a load is requested, then pulse done once
  always_ff @(posedge clk) begin
    if (!rst_n || load_req) begin
      cnt       <= LOAD_CYC;
      load_done <= 1'b0;
    end else begin
      if (cnt > 0) cnt <= cnt - 1;
      load_done <= (cnt == 1);
    end
  end
endmodule : drs_env_model

// *** testbench/testbench.sv ***
// Self-checking bench for the ready sequencer and strap latch
`timescale 1ns/100ps
`include "drs_cfg.svh"
module testbench;
  localparam int PLL = 8;
  logic clk, rst_n, por, pin_rst, wake, pll, link, done, reload, ready, link_up;
  logic [1:0]  rsp;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rd_v, rnd;
  logic [3:0]  wstrb;
  logic        awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic [9:0]  pins, e_s;
  drs_pkg::drs_cfg_t cfg;
  int miscompares, cmp_count, n, k;

  drs_ready_seq #(.PLL_LOCK_CYC(PLL)) i_dut (.clk(clk), .rst_n(rst_n), .por_event(por),
    .pin_reset_event(pin_rst), .eeprom_done(done), .wake_event(wake), .pll_locked(pll),
    .mii_link_pin(link), .eeprom_range_pin(pins[9]), .port_mode_pin(pins[8:7]),
    .link_pol_pin(pins[6]), .tx_shift_pin(pins[5:4]), .phy_a_fiber_strap(pins[3]),
    .phy_b_fiber_strap(pins[2]), .phy_a_los_select_strap(pins[1]),
    .phy_b_los_select_strap(pins[0]), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .eeprom_reload_reg(reload), .ready_reg(ready), .mii_link_up_reg(link_up), .cfg_out(cfg));
  drs_env_model i_env (.clk(clk), .rst_n(rst_n), .load_req(reload), .load_done(done));

  // Free-running 40 MHz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic report_and_stop();
    if (miscompares == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : report_and_stop

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
      miscompares++;
    end
  endtask : chk

  // A wait that runs out counts as a mismatch and ends the run
  task automatic tmo();
    miscompares++;
    report_and_stop();
  endtask : tmo

  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr

  // Write: address and data offered together, each dropped at its own handshake
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    bit at, wt, bt;
    int i;
    @(posedge clk);
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= s;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(negedge clk);
      at = awvalid && awready === 1'b1;
      wt = wvalid && wready === 1'b1;
      bt = bvalid === 1'b1;
      if (bt) rsp = bresp;
      @(posedge clk);
      if (at) awvalid <= 1'b0;
      if (wt) wvalid <= 1'b0;
      if (bt) begin
        bready <= 1'b0;
        break;
      end
    end
    if (i == 50) tmo();
  endtask : wr

  task automatic rd(input logic [7:0] a);
    bit at, rt;
    int i;
    @(posedge clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(negedge clk);
      at = arvalid && arready === 1'b1;
      rt = rvalid === 1'b1;
      if (rt) rsp = rresp;
      if (rt) rd_v = rdata;
      @(posedge clk);
      if (at) arvalid <= 1'b0;
      if (rt) begin
        rready <= 1'b0;
        break;
      end
    end
    if (i == 50) tmo();
  endtask : rd

  task automatic wait_ready(output int c);
    for (c = 0; c < 300 && ready !== 1'b1; c++) @(negedge clk);
    if (c == 300) tmo();
  endtask : wait_ready

  // Main sequence; the reference model keeps the expected strap word in e_s
  initial begin
    {por, pin_rst, wake, link, pins, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata, wstrb} = '0;
    pll = 1'b1;
    rst_n = 1'b0;
    rnd = 32'h462b;
    e_s = '0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    for (k = 0; k < 8; k++) begin
      repeat (10) rnd = lfsr(rnd);
      @(posedge clk);
      pins <= rnd[9:0];
      repeat (4) @(posedge clk);
      if (k % 4 != 3) e_s = rnd[9:0];
      if (k % 4 == 0) por <= 1'b1;
      if (k % 4 == 1) pin_rst <= 1'b1;
      if (k % 4 == 2) wr(`DRS_OFF_RSTCTL, 32'h40, 4'h1);
      if (k % 4 == 3) wr(`DRS_OFF_RSTCTL, 32'h01, 4'h1);
      @(posedge clk);
      {por, pin_rst} <= 2'b00;
      rd(`DRS_OFF_PMC);
      chk("pmc_loading", 32'h0, {31'h0, rd_v[0]});
      wait_ready(n);
      rd(`DRS_OFF_INTSTS);
      chk("int_ready", 32'h1, {31'h0, rd_v[30]});
      wr(`DRS_OFF_INTSTS, 32'h40000000, 4'h8);
      rd(`DRS_OFF_INTSTS);
      chk("int_clear", 32'h0, {31'h0, rd_v[30]});
      wr(`DRS_OFF_PMC, 32'h0, 4'hf);
      chk("wr_okay", `DRS_OKAY, rsp);
      rd(`DRS_OFF_PMC);
      chk("pmc_ready", 32'h1, {31'h0, rd_v[0]});
      rd(`DRS_OFF_HWC);
      chk("hwc_ready", 32'h1, {31'h0, rd_v[27]});
      rd(`DRS_OFF_STRAP);
      chk("strap", {22'h0, e_s}, rd_v);
      chk("rd_okay", `DRS_OKAY, rsp);
      chk("range", e_s[9], cfg.eeprom_large);
      chk("tx_ns", 10 * e_s[5:4], cfg.tx_shift_ns);
      chk("fx", e_s[3:0], {cfg.phy_a_fx, cfg.phy_b_fx, cfg.phy_a_los_mode,
          cfg.phy_b_los_mode});
      if (e_s[8:7] != 2'b01) begin
        chk("mii_used", e_s[8], cfg.mii_used);
        chk("phya", (e_s[8:7] == 2'b11) ? 2 : 0, cfg.phya_port);
        chk("phyb", 1, cfg.phyb_port);
        if (e_s[8]) chk("mii", (e_s[7]) ? 0 : 2, cfg.mii_port);
      end
      @(posedge clk);
      link <= rnd[12];
      pins <= ~pins;
      repeat (6) @(posedge clk);
      chk("link", rnd[12] == e_s[6], link_up);
    end
    // Error responses for an unmapped place, constant test word
    rd(8'h40);
    chk("rd_decerr", `DRS_DECERR, rsp);
    wr(8'h40, 32'h0, 4'hf);
    chk("wr_decerr", `DRS_DECERR, rsp);
    rd(`DRS_OFF_TEST);
    chk("test", `DRS_TEST_VALUE, rd_v);
    // Sleep, then wake with the PLL held unlocked for a while
    pll <= 1'b0;
    wr(`DRS_OFF_PMC, 32'h20000000, 4'h8);
    wr(`DRS_OFF_PMC, 32'h30000000, 4'h8);
    @(negedge clk);
    chk("sleep", 1'b0, ready);
    wake <= 1'b1;
    repeat (30) @(posedge clk);
    chk("no_pll", 1'b0, ready);
    rd(`DRS_OFF_PMC);
    chk("wake_clr", 4'h0, rd_v[31:28]);
    @(posedge clk);
    pll  <= 1'b1;
    wake <= 1'b0;
    wait_ready(n);
    chk("pll_wait", 1'b1, n >= PLL);
    report_and_stop();
  end
endmodule : testbench
